// ===== nibble_exec_pkg.sv
// Package: register map, fields, opcodes and states of the nibble execution unit
package nibble_exec_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] ADDR_INSTR = 12'h000;
	localparam logic [11:0] ADDR_FLAGS = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_PC = 12'h00C;
	localparam logic [11:0] ADDR_GREG = 12'h010;
	localparam logic [11:0] ADDR_MEM = 12'h040;
	localparam int GREG_WORDS = 4;
	localparam int MEM_WORDS = 16;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int INSTR_OP_LSB = 0;
	localparam int INSTR_IMM_LSB = 4;
	localparam int INSTR_MADDR_LSB = 8;
	localparam int INSTR_RIDX_LSB = 12;
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_ZERO = 1;
	localparam int FLAG_DECIMAL = 2;
	localparam int FLAG_COMPARE_ONLY = 3;
	localparam int STAT_SKIP = 0;
	localparam int STAT_SUPPRESSED = 1;
	localparam int STAT_ILLEGAL = 2;
	// ****************************************
	// Reset values and PC increment
	// ****************************************
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [8:0] PC_RST = 9'h000;
	localparam logic [8:0] PC_STEP = 9'h001;
	localparam logic [15:0] INSTR_RST = 16'h0000;
	localparam logic [3:0] NIB_RST = 4'h0;
	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_SKIP_EQ = 4'h1;
	localparam logic [3:0] OP_SKIP_NE = 4'h2;
	localparam logic [3:0] OP_SKIP_GE = 4'h3;
	localparam logic [3:0] OP_SKIP_LT = 4'h4;
	localparam logic [3:0] OP_ROT_RIGHT = 4'h5;
	localparam logic [3:0] OP_ADD_CARRY = 4'h6;
	// ****************************************
	// Bus states
	// ****************************************
	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_DONE = 2'b10
	} apb_state_e;
endpackage : nibble_exec_pkg

// ===== alu_if.sv
// Interface between the core control and the nibble ALU
`timescale 1ns/1ps
interface alu_if;
	logic [3:0] op;
	logic [3:0] imm;
	logic [3:0] mem_val;
	logic [3:0] reg_val;
	logic carry_in;
	logic compare_only;
	logic [3:0] res;
	logic carry_out;
	logic skip;
	logic wr_reg;
	logic legal;
	modport core (output op, imm, mem_val, reg_val, carry_in, compare_only,
		input res, carry_out, skip, wr_reg, legal);
	modport alu (input op, imm, mem_val, reg_val, carry_in, compare_only,
		output res, carry_out, skip, wr_reg, legal);
endinterface : alu_if

// ===== nibble_alu.sv
// Combinational nibble ALU: compare-skip, right rotate, add with carry
`timescale 1ns/1ps
module nibble_alu
	import nibble_exec_pkg::*;
(
	alu_if.alu bus
);
	always_comb begin
		bus.res = bus.reg_val;
		bus.carry_out = bus.carry_in;
		bus.skip = 1'b0;
		bus.wr_reg = 1'b0;
		bus.legal = 1'b1;
		unique case (bus.op)
			OP_NOP: begin
				bus.legal = 1'b1;
			end
			OP_SKIP_EQ: begin
				bus.skip = (bus.mem_val == bus.imm);
			end
			OP_SKIP_NE: begin
				bus.skip = (bus.mem_val != bus.imm);
			end
			OP_SKIP_GE: begin
				bus.skip = (bus.mem_val >= bus.imm);
			end
			OP_SKIP_LT: begin
				bus.skip = (bus.mem_val < bus.imm);
			end
			OP_ROT_RIGHT: begin
				{bus.res, bus.carry_out} = {bus.carry_in, bus.reg_val};
				bus.wr_reg = 1'b1;
			end
			OP_ADD_CARRY: begin
				{bus.carry_out, bus.res} = {1'b0, bus.reg_val} + {1'b0, bus.reg_val}
					+ {4'h0, bus.carry_in};
				bus.wr_reg = !bus.compare_only;
			end
			default: begin
				bus.legal = 1'b0;
			end
		endcase
	end
endmodule : nibble_alu

// ===== nibble_compare_skip_rotate.sv
// Nibble compare-skip and rotate execution unit with APB register access
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module nibble_compare_skip_rotate
	import nibble_exec_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic skip_pending
);
	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic in_block(input logic [11:0] a, input logic [11:0] base,
		input int words);
		return (a >= base) && (a < base + 12'(4 * words)) && (a[1:0] == 2'b00);
	endfunction : in_block

	apb_state_e st_q, st_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [15:0] instr_q, instr_d;
	logic [3:0] flags_q, flags_d;
	logic skip_q, skip_d;
	logic supp_q, supp_d;
	logic ill_q, ill_d;
	logic [8:0] pc_q, pc_d;
	logic [3:0][3:0] greg_q, greg_d;
	logic [15:0][3:0] mem_q, mem_d;

	logic acc, wr_done, issue, exec, suppress, mapped, hit_greg, hit_mem;
	logic [3:0] op, imm, mem_nib, reg_nib, rot_exp;
	logic [3:0] maddr;
	logic [1:0] ridx;
	logic [4:0] add_exp;
	logic is_skip;
	alu_if alu ();

	assign acc = psel && penable;
	assign wr_done = acc && pready_q && pwrite && mapped;
	assign issue = wr_done && (paddr == ADDR_INSTR);
	assign exec = issue && !skip_q;
	assign suppress = issue && skip_q;
	assign hit_greg = in_block(paddr, ADDR_GREG, GREG_WORDS);
	assign hit_mem = in_block(paddr, ADDR_MEM, MEM_WORDS);
	assign mapped = hit_greg || hit_mem || (paddr == ADDR_INSTR) || (paddr == ADDR_FLAGS)
		|| (paddr == ADDR_STATUS) || (paddr == ADDR_PC);
	assign op = pwdata[INSTR_OP_LSB +: 4];
	assign imm = pwdata[INSTR_IMM_LSB +: 4];
	assign maddr = pwdata[INSTR_MADDR_LSB +: 4];
	assign ridx = pwdata[INSTR_RIDX_LSB +: 2];
	assign mem_nib = mem_q[maddr];
	assign reg_nib = greg_q[ridx];
	assign rot_exp = {flags_q[FLAG_CARRY], reg_nib[3:1]};
	assign add_exp = {1'b0, reg_nib} + {1'b0, reg_nib} + {4'h0, flags_q[FLAG_CARRY]};
	assign is_skip = (op == OP_SKIP_EQ) || (op == OP_SKIP_NE) || (op == OP_SKIP_GE)
		|| (op == OP_SKIP_LT);

	assign alu.op = op;
	assign alu.imm = imm;
	assign alu.mem_val = mem_nib;
	assign alu.reg_val = reg_nib;
	assign alu.carry_in = flags_q[FLAG_CARRY];
	assign alu.compare_only = flags_q[FLAG_COMPARE_ONLY];

	nibble_alu u_alu (
		.bus(alu)
	);

	// ****************************************
	// APB slave
	// ****************************************
	always_comb begin
		st_d = st_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		unique case (st_q)
			APB_IDLE: begin
				if (acc) begin
					st_d = APB_DONE;
					pready_d = 1'b1;
					pslverr_d = !mapped;
					prdata_d = 32'h0000_0000;
					if (!pwrite && paddr == ADDR_INSTR) prdata_d = {16'h0000, instr_q};
					if (!pwrite && paddr == ADDR_FLAGS) prdata_d = {28'h0000000, flags_q};
					if (!pwrite && paddr == ADDR_STATUS) prdata_d = {29'h0, ill_q, supp_q, skip_q};
					if (!pwrite && paddr == ADDR_PC) prdata_d = {23'h0, pc_q};
					if (!pwrite && hit_greg) prdata_d = {28'h0000000, greg_q[paddr[3:2]]};
					if (!pwrite && hit_mem) prdata_d = {28'h0000000, mem_q[paddr[5:2]]};
				end
			end
			APB_DONE: begin
				st_d = APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= APB_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// ****************************************
	// Execution state
	// ****************************************
	always_comb begin
		instr_d = instr_q;
		flags_d = flags_q;
		skip_d = skip_q;
		supp_d = supp_q;
		ill_d = ill_q;
		pc_d = pc_q;
		greg_d = greg_q;
		mem_d = mem_q;
		if (issue) begin
			instr_d = pwdata[15:0];
			pc_d = pc_q + PC_STEP;
			if (skip_q) begin
				skip_d = 1'b0;
				supp_d = 1'b1;
			end else begin
				supp_d = 1'b0;
				skip_d = alu.skip;
				ill_d = !alu.legal;
				flags_d[FLAG_CARRY] = alu.carry_out;
				if (alu.wr_reg) greg_d[ridx] = alu.res;
			end
		end
		if (wr_done && paddr == ADDR_FLAGS) flags_d = pwdata[3:0];
		if (wr_done && hit_greg) greg_d[paddr[3:2]] = pwdata[3:0];
		if (wr_done && hit_mem) mem_d[paddr[5:2]] = pwdata[3:0];
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			instr_q <= INSTR_RST;
			flags_q <= FLAGS_RST;
			skip_q <= 1'b0;
			supp_q <= 1'b0;
			ill_q <= 1'b0;
			pc_q <= PC_RST;
			greg_q <= {GREG_WORDS{NIB_RST}};
			mem_q <= {MEM_WORDS{NIB_RST}};
		end else begin
			instr_q <= instr_d;
			flags_q <= flags_d;
			skip_q <= skip_d;
			supp_q <= supp_d;
			ill_q <= ill_d;
			pc_q <= pc_d;
			greg_q <= greg_d;
			mem_q <= mem_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign skip_pending = skip_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence s_rot;
		exec && op == OP_ROT_RIGHT;
	endsequence

	property p_eq;
		exec && op == OP_SKIP_EQ && mem_nib == imm |=> skip_q;
	endproperty
	a_eq: assert property (p_eq) else $error("equal skip missed");
	property p_ne;
		exec && op == OP_SKIP_NE |=> skip_q == $past(alu.skip) && $past(mem_nib != imm) == skip_q;
	endproperty
	a_ne: assert property (p_ne) else $error("not equal skip wrong");
	property p_ge;
		exec && op == OP_SKIP_GE && mem_nib < imm |=> !skip_q;
	endproperty
	a_ge: assert property (p_ge) else $error("greater or equal skipped wrongly");
	property p_lt;
		exec && op == OP_SKIP_LT |=> skip_q == $past(mem_nib < imm);
	endproperty
	a_lt: assert property (p_lt) else $error("less than skip wrong");
	property p_uns;
		exec && op == OP_SKIP_GE && mem_nib == 4'h8 && imm == 4'h7 |=> skip_q;
	endproperty
	a_uns: assert property (p_uns) else $error("compare not unsigned");
	property p_ill;
		exec && !alu.legal |=> ill_q && $stable(greg_q) && $stable(mem_q);
	endproperty
	a_ill: assert property (p_ill) else $error("illegal opcode acted");
	property p_rot_mode;
		s_rot |=> $stable(flags_q[FLAG_ZERO]) && greg_q[$past(ridx)] == $past(rot_exp);
	endproperty
	a_rot_mode: assert property (p_rot_mode) else $error("rotate not stored");
	property p_rot_carry;
		s_rot |=> flags_q[FLAG_CARRY] == $past(reg_nib[0]);
	endproperty
	a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong");
	property p_add;
		exec && op == OP_ADD_CARRY && !flags_q[FLAG_COMPARE_ONLY]
			|=> {flags_q[FLAG_CARRY], greg_q[$past(ridx)]} == $past(add_exp);
	endproperty
	a_add: assert property (p_add) else $error("left rotate wrong");
	property p_chain;
		s_rot |-> alu.res[3] == flags_q[FLAG_CARRY] && alu.carry_out == reg_nib[0];
	endproperty
	a_chain: assert property (p_chain) else $error("rotate chain broken");
	property p_keep;
		exec && is_skip |=> $stable(flags_q) && $stable(greg_q);
	endproperty
	a_keep: assert property (p_keep) else $error("skip changed flags");
	property p_supp;
		suppress |=> $stable(greg_q) && $stable(flags_q) && $stable(mem_q) && !skip_q
			&& supp_q && pc_q == $past(pc_q) + PC_STEP;
	endproperty
	a_supp: assert property (p_supp) else $error("suppressed slot acted");
endmodule : nibble_compare_skip_rotate

// ===== nibble_compare_skip_rotate_tb.sv
// Self-checking testbench of the nibble compare-skip and rotate unit
`timescale 1ns/1ps
module nibble_compare_skip_rotate_tb;
	import nibble_exec_pkg::*;
	logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, skip_pending, e, sk;
	logic sp, il;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] g [4];
	logic [3:0] m [16];
	logic [3:0] fl;
	logic [8:0] pc;
	logic [12:0] v;
	int fail_count, checks_done, seed, cyc;
	nibble_compare_skip_rotate u_nibble_compare_skip_rotate (.ref_clk(ref_clk), .arst_n(arst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .skip_pending(skip_pending));
	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;
	// ****************************************
	// Helpers
	// ****************************************
	task test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task rdc(input logic [11:0] a, input logic [31:0] exp, input string msg);
		apb(1'b0, a, 32'h0);
		chk(r, exp, msg);
	endtask : rdc
	function automatic logic want_skip(input logic [3:0] op, input logic [3:0] mv,
		input logic [3:0] iv);
		case (op)
			OP_SKIP_EQ: return mv == iv;
			OP_SKIP_NE: return mv != iv;
			OP_SKIP_GE: return mv >= iv;
			default: return mv < iv;
		endcase
	endfunction : want_skip
	task issue(input logic [3:0] op, input logic [3:0] imm, input logic [3:0] ma,
		input logic [1:0] ri);
		logic [4:0] s;
		apb(1'b1, ADDR_INSTR, {16'h0000, 2'b00, ri, ma, imm, op});
		pc = pc + PC_STEP;
		sp = sk;
		il = sk ? il : (op > OP_ADD_CARRY);
		if (sk) begin
			sk = 1'b0;
		end else if (op >= OP_SKIP_EQ && op <= OP_SKIP_LT) begin
			sk = want_skip(op, m[ma], imm);
		end else if (op == OP_ROT_RIGHT) begin
			{g[ri], fl[FLAG_CARRY]} = {fl[FLAG_CARRY], g[ri]};
		end else if (op == OP_ADD_CARRY) begin
			s = {1'b0, g[ri]} + {1'b0, g[ri]} + {4'h0, fl[FLAG_CARRY]};
			fl[FLAG_CARRY] = s[4];
			if (!fl[FLAG_COMPARE_ONLY]) g[ri] = s[3:0];
		end
		chk({31'h0, skip_pending}, {31'h0, sk}, "skip");
		rdc(ADDR_FLAGS, {28'h0, fl}, "flags");
		rdc(ADDR_PC, {23'h0, pc}, "pc");
		rdc(ADDR_STATUS, {29'h0, il, sp, sk}, "status");
		rdc(ADDR_GREG + {8'h00, ri, 2'b00}, {28'h0, g[ri]}, "greg");
		rdc(ADDR_MEM + {6'h00, ma, 2'b00}, {28'h0, m[ma]}, "mem");
	endtask : issue
	task vchk();
		for (int i = 1; i < 4; i++) begin
			rdc(ADDR_GREG + 12'(4 * i), {28'h0, v[(3 - i) * 4 +: 4]}, "chain");
		end
		rdc(ADDR_FLAGS, {31'h0, v[12]}, "chain carry");
	endtask : vchk
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [3:0] a, b, ma;
		logic [1:0] ri;
		{arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{fail_count, checks_done, cyc} = '0;
		seed = 12;
		fl = FLAGS_RST;
		pc = PC_RST;
		sk = 1'b0;
		sp = 1'b0;
		il = 1'b0;
		foreach (g[i]) g[i] = NIB_RST;
		foreach (m[i]) m[i] = NIB_RST;
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		rdc(ADDR_STATUS, 32'h0, "status");
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped");
		$display("test reset done");
		for (int k = 0; k < 48; k++) begin
			a = k < 12 ? 4'h8 : 4'($random(seed));
			b = k < 12 ? 4'(7 + k / 4) : 4'($random(seed));
			ma = 4'($random(seed));
			ri = 2'($random(seed));
			fl = 4'($random(seed));
			m[ma] = a;
			g[ri] = 4'($random(seed));
			apb(1'b1, ADDR_FLAGS, {28'h0, fl});
			apb(1'b1, ADDR_MEM + {6'h00, ma, 2'b00}, {28'h0, a});
			apb(1'b1, ADDR_GREG + {8'h00, ri, 2'b00}, {28'h0, g[ri]});
			issue(OP_SKIP_EQ + 4'(k % 4), b, ma, ri);
			issue(OP_ROT_RIGHT + 4'(k / 4 % 2), 4'($random(seed)), ma, ri);
		end
		$display("test compare done");
		fl = 4'h0;
		v = 13'b0_1000_0100_0010;
		apb(1'b1, ADDR_FLAGS, 32'h0);
		for (int i = 1; i < 4; i++) begin
			g[i] = v[(3 - i) * 4 +: 4];
			apb(1'b1, ADDR_GREG + 12'(4 * i), {28'h0, g[i]});
		end
		for (int i = 1; i < 4; i++) issue(OP_ROT_RIGHT, 4'h0, 4'h0, 2'(i));
		v = {v[0], v[12:1]};
		vchk();
		for (int i = 3; i > 0; i--) issue(OP_ADD_CARRY, 4'h0, 4'h0, 2'(i));
		v = {v[11:0], v[12]};
		vchk();
		$display("test chain done");
		for (int k = 7; k < 16; k++) begin
			issue(4'(k), 4'($random(seed)), 4'($random(seed)), 2'($random(seed)));
			issue(OP_NOP, 4'h0, 4'h0, 2'h0);
		end
		issue(4'h8, 4'h0, 4'h0, 2'h0);
		issue(OP_SKIP_EQ, m[0], 4'h0, 2'h0);
		issue(4'h7, 4'h0, 4'h0, 2'h0);
		$display("test illegal done");
		test_done();
	end
endmodule : nibble_compare_skip_rotate_tb
